// *** asp_top.sv ***
// dual async serial port: APB registers, queues, flow control, interrupts, DMA requests
// assumes APB on pclk, DMA reaches the data register over the same APB,
// serial pins and cts_n asynchronous to pclk; DEPTH a power of two
module asp_top #(
  parameter int NPORT = 2, // number of serial ports
  parameter int DEPTH = 4 // entries per transmit and receive queue
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [asp_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [NPORT-1:0] rxd, // serial inputs
  input wire logic [NPORT-1:0] cts_n, // clear to send, active low
  output logic [NPORT-1:0] txd, // serial outputs
  output logic [NPORT-1:0] rts_n, // request to send, active low
  output logic [NPORT-1:0] dma_tx_req, // transmit queue has room
  output logic [NPORT-1:0] dma_rx_req, // receive queue has data
  output logic irq // any unmasked event
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PSW = (NPORT > 1) ? $clog2(NPORT) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [NPORT-1:0][15:0] ctrl;
    logic [NPORT-1:0][15:0] div;
    logic [NPORT-1:0][15:0] thr;
    logic [NPORT-1:0][asp_pkg::NEV-1:0] stat;
    logic [NPORT-1:0][asp_pkg::NEV-1:0] mask;
    logic [NPORT-1:0][DEPTH-1:0][9:0] tq;
    logic [NPORT-1:0][PW:0] tcnt;
    logic [NPORT-1:0][PW-1:0] trp;
    logic [NPORT-1:0][DEPTH-1:0][8:0] rq;
    logic [NPORT-1:0][PW:0] rcnt;
    logic [NPORT-1:0][PW-1:0] rrp;
    asp_pkg::asp_txe_t [NPORT-1:0] tent;
    logic [NPORT-1:0] cts1;
    logic [NPORT-1:0] cts2;
    logic [NPORT-1:0] rts_n;
    logic [NPORT-1:0] tgo;
    logic [NPORT-1:0] listen;
    logic [NPORT-1:0] dtx;
    logic [NPORT-1:0] drx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } asp_top_st_t;

  asp_top_st_t s, n;
  asp_pkg::asp_cfg_t [NPORT-1:0] cfg;
  asp_pkg::asp_rxr_t [NPORT-1:0] rxr;
  logic [NPORT-1:0] tbusy;
  logic acc, hit, sel, okf, tpush, tpop, rpop, irqv;
  logic [PSW-1:0] pt;
  logic [2:0] rg;
  logic [9:0] tnew;
  logic [PW-1:0] wp;
  logic [PW-1:0] rwp;
  logic [asp_pkg::NEV-1:0] ev;
  logic [asp_pkg::NEV-1:0] w1c;
  logic [31:0] rdv;

  // bus decode, register file and per-port queue control
  always_comb begin
    n = s;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    irqv = 1'b0;
    acc = psel && penable && !s.pready; // one wait state, then ready
    pt = paddr[asp_pkg::PORT_BIT +: PSW];
    rg = paddr[4:2];
    hit = (paddr[asp_pkg::ADDR_W-1:asp_pkg::PORT_BIT+PSW] == '0)
      && (32'(pt) < NPORT) && (rg <= asp_pkg::REG_THR);
    // read mux from the current state of the addressed port
    rdv = 32'h0000_0000;
    if (hit) begin
      case (rg)
        asp_pkg::REG_DATA: rdv = 32'(s.rq[pt][s.rrp[pt]]);
        asp_pkg::REG_CTRL: rdv = 32'(s.ctrl[pt]);
        asp_pkg::REG_DIV: rdv = 32'(s.div[pt]);
        asp_pkg::REG_STAT: rdv = 32'({s.tcnt[pt] == FULL, s.rcnt[pt] != '0, 2'b00, s.stat[pt]});
        asp_pkg::REG_MASK: rdv = 32'(s.mask[pt]);
        asp_pkg::REG_THR: rdv = 32'(s.thr[pt]);
        default: rdv = 32'h0000_0000;
      endcase
    end
    if (acc) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = pwrite ? 32'h0000_0000 : rdv;
    end
    // each port runs on its own state with no shared timing
    for (int p = 0; p < NPORT; p++) begin
      ev = '0;
      w1c = '0;
      tpush = 1'b0;
      tpop = 1'b0;
      rpop = 1'b0;
      okf = 1'b1;
      tnew = 10'h000;
      sel = acc && hit && (pt == PSW'(p));
      wp = PW'(s.trp[p] + s.tcnt[p][PW-1:0]);
      rwp = PW'(s.rrp[p] + s.rcnt[p][PW-1:0]);
      // clear-to-send synchroniser
      n.cts1[p] = cts_n[p];
      n.cts2[p] = s.cts1[p];
      // register writes and data pops
      if (sel && pwrite) begin
        case (rg)
          asp_pkg::REG_DATA: begin
            tpush = (s.tcnt[p] != FULL); // full queue drops the write
            tnew = {1'b0, pwdata[8:0]};
          end
          asp_pkg::REG_BRK: begin
            tpush = (s.tcnt[p] != FULL); // break queued in order
            tnew = {1'b1, 1'b0, pwdata[7:0]};
          end
          asp_pkg::REG_CTRL: n.ctrl[p] = pwdata[15:0];
          asp_pkg::REG_DIV: n.div[p] = pwdata[15:0];
          asp_pkg::REG_STAT: w1c = pwdata[asp_pkg::NEV-1:0];
          asp_pkg::REG_MASK: n.mask[p] = pwdata[asp_pkg::NEV-1:0];
          asp_pkg::REG_THR: n.thr[p] = pwdata[15:0];
          default: w1c = '0;
        endcase
      end
      if (sel && !pwrite && (rg == asp_pkg::REG_DATA) && (s.rcnt[p] != '0)) begin
        rpop = 1'b1; // processor or DMA read drains the queue
      end
      if (tpush) begin
        n.tq[p][wp] = tnew;
      end
      // hand the head entry to the serialiser, gated by clear to send
      n.tgo[p] = 1'b0;
      if (!tbusy[p] && !s.tgo[p] && (s.tcnt[p] != '0)
          && (!s.ctrl[p][asp_pkg::CTL_AFC] || !s.cts2[p])) begin
        n.tgo[p] = 1'b1;
        n.tent[p] = s.tq[p][s.trp[p]];
        n.trp[p] = s.trp[p] + PW'(1);
        tpop = 1'b1;
      end
      n.tcnt[p] = s.tcnt[p] + (PW + 1)'(tpush) - (PW + 1)'(tpop);
      if (tpop && (s.tcnt[p] == (PW + 1)'(1)) && !tpush) ev[asp_pkg::ST_TXE] = 1'b1;
      // received frame: multi-drop filter, errors, queue push
      if (rxr[p].vld) begin
        if (s.ctrl[p][asp_pkg::CTL_ADR]) begin
          if (rxr[p].d[8]) begin
            n.listen[p] = (rxr[p].d[7:0] == s.thr[p][asp_pkg::THR_ADR +: 8]);
            okf = n.listen[p];
          end else begin
            okf = s.listen[p]; // data for other nodes stays silent
          end
        end
        if (okf) begin
          ev[asp_pkg::ST_PERR] = rxr[p].perr;
          ev[asp_pkg::ST_FERR] = rxr[p].ferr;
          ev[asp_pkg::ST_BRK] = rxr[p].brk;
          if (!rxr[p].brk) begin
            if ((s.rcnt[p] != FULL) || rpop) begin
              n.rq[p][rwp] = rxr[p].d;
              ev[asp_pkg::ST_RXD] = 1'b1;
            end else begin
              ev[asp_pkg::ST_OVR] = 1'b1;
            end
          end
        end
      end
      if (rpop) n.rrp[p] = s.rrp[p] + PW'(1);
      n.rcnt[p] = s.rcnt[p] + (PW + 1)'(ev[asp_pkg::ST_RXD]) - (PW + 1)'(rpop);
      // sticky events, a new event wins over a clear in the same cycle
      n.stat[p] = (s.stat[p] & ~w1c) | ev;
      // request to send from receive fill thresholds
      if (!s.ctrl[p][asp_pkg::CTL_AFC]) begin
        n.rts_n[p] = 1'b0;
      end else if (8'(n.rcnt[p]) >= 8'(s.thr[p][asp_pkg::THR_HI +: 4])) begin
        n.rts_n[p] = 1'b1;
      end else if (8'(n.rcnt[p]) <= 8'(s.thr[p][asp_pkg::THR_LO +: 4])) begin
        n.rts_n[p] = 1'b0;
      end
      // DMA requests as queue levels, both directions at once
      n.dtx[p] = s.ctrl[p][asp_pkg::CTL_DTX] && (n.tcnt[p] != FULL);
      n.drx[p] = s.ctrl[p][asp_pkg::CTL_DRX] && (n.rcnt[p] != '0);
      irqv = irqv | (|(n.stat[p] & n.mask[p]));
    end
    n.irq = irqv;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= {NPORT{asp_pkg::CTRL_RST}};
      s.div <= {NPORT{asp_pkg::DIV_RST}};
      s.thr <= {NPORT{asp_pkg::THR_RST}};
      s.cts1 <= '1;
      s.cts2 <= '1;
      s.rts_n <= '1;
    end else begin
      s <= n;
    end
  end

  // one serialiser and one deserialiser per port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    assign cfg[p].len = s.ctrl[p][asp_pkg::CTL_LEN +: 2];
    assign cfg[p].pen = s.ctrl[p][asp_pkg::CTL_PEN];
    assign cfg[p].podd = s.ctrl[p][asp_pkg::CTL_PODD];
    assign cfg[p].adr = s.ctrl[p][asp_pkg::CTL_ADR];
    assign cfg[p].stop = s.ctrl[p][asp_pkg::CTL_STOP +: 2];
    assign cfg[p].irda = s.ctrl[p][asp_pkg::CTL_IRDA];
    assign cfg[p].gap = s.ctrl[p][asp_pkg::CTL_GAP +: 4];
    assign cfg[p].div = s.div[p];

    asp_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg[p]),
      .go(s.tgo[p]),
      .ent(s.tent[p]),
      .busy(tbusy[p]),
      .txd(txd[p])
    );

    asp_rx u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg[p]),
      .rxd(rxd[p]),
      .res(rxr[p])
    );
  end

  // outputs straight from the state register
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rts_n = s.rts_n;
  assign dma_tx_req = s.dtx;
  assign dma_rx_req = s.drx;
  assign irq = s.irq;
endmodule // asp_top

// *** asp_pkg.sv ***
// shared constants and carrier types of the dual async serial port
// assumes one system clock and APB register access with 32-bit data
package asp_pkg;
  // register word index within a port window (byte address = index * 4)
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_CTRL = 3'h1;
  localparam logic [2:0] REG_DIV = 3'h2;
  localparam logic [2:0] REG_BRK = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam logic [2:0] REG_MASK = 3'h5;
  localparam logic [2:0] REG_THR = 3'h6;
  localparam int PORT_BIT = 5; // each port owns 32 bytes
  localparam int ADDR_W = 12;
  // control fields
  localparam int CTL_LEN = 0;
  localparam int CTL_PEN = 2;
  localparam int CTL_PODD = 3;
  localparam int CTL_ADR = 4;
  localparam int CTL_STOP = 5;
  localparam int CTL_AFC = 7;
  localparam int CTL_IRDA = 8;
  localparam int CTL_DTX = 9;
  localparam int CTL_DRX = 10;
  localparam int CTL_GAP = 11;
  // threshold fields
  localparam int THR_HI = 0;
  localparam int THR_LO = 4;
  localparam int THR_ADR = 8;
  // status event bits
  localparam int NEV = 6;
  localparam int ST_RXD = 0;
  localparam int ST_PERR = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OVR = 3;
  localparam int ST_BRK = 4;
  localparam int ST_TXE = 5;
  // reset values and fixed counts
  localparam logic [15:0] CTRL_RST = 16'h0003;
  localparam logic [15:0] DIV_RST = 16'h0004;
  localparam logic [15:0] THR_RST = 16'h0013;
  localparam int BASE_LEN = 5;
  localparam int STOP_HALVES = 2;

  typedef struct packed {
    logic [1:0] len; // data bits minus five
    logic pen;
    logic podd;
    logic adr;
    logic [1:0] stop; // half bits beyond one stop bit
    logic irda;
    logic [3:0] gap; // extra idle bit times
    logic [15:0] div; // clocks per half bit minus one
  } asp_cfg_t;

  typedef struct packed {
    logic brk;
    logic [8:0] d; // address bit and data, or break length
  } asp_txe_t;

  typedef struct packed {
    logic vld;
    logic [8:0] d;
    logic perr;
    logic ferr;
    logic brk;
  } asp_rxr_t;
endpackage

// *** asp_tx.sv ***
// transmit serialiser: start, data, address, parity, stop, gap, break, IrDA pulses
// assumes go is a one-cycle pulse given only while busy is low
module asp_tx (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input asp_pkg::asp_cfg_t cfg, // character format
  input wire logic go, // start one queue entry
  input asp_pkg::asp_txe_t ent, // entry to send
  output logic busy, // frame in progress
  output logic txd // serial output
);
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_STOP} asp_txst_t;
  typedef struct packed {
    asp_txst_t st;
    logic [15:0] dv;
    logic ph;
    logic [8:0] nb;
    logic [11:0] sh;
    logic [5:0] sp;
    logic [15:0] ip;
    logic txd;
  } asp_tx_st_t;
  asp_tx_st_t s, n;
  logic tick, par;
  logic [7:0] dm;
  logic [11:0] fr;
  logic [3:0] k;
  logic [17:0] pl;
  logic [15:0] plen;

  // frame building and bit timing
  always_comb begin
    n = s;
    tick = (s.dv == 16'h0000);
    n.dv = tick ? cfg.div : s.dv - 16'h0001; // half-bit divider
    pl = (18'(cfg.div) + 18'h00001) * 18'h00003;
    plen = 16'(pl >> 3); // 3/16 of a bit
    if (plen == 16'h0000) plen = 16'h0001;
    dm = ent.d[7:0] & (8'hFF >> (2'h3 - cfg.len)); // five to eight bits
    par = (^dm) ^ cfg.podd;
    k = 4'(cfg.len) + 4'h6;
    fr = 12'(dm) << 1;
    if (cfg.adr) fr = fr | (12'(ent.d[8]) << k); // address bit
    if (cfg.pen) fr = fr | (12'(par) << (k + 4'(cfg.adr)));
    if (s.ip != 16'h0000) n.ip = s.ip - 16'h0001;
    case (s.st)
      TX_IDLE: begin
        if (go) begin
          n.st = TX_SEND;
          n.dv = cfg.div;
          n.ph = 1'b0;
          // stop halves 2..5 plus inter-frame gap
          n.sp = 6'(asp_pkg::STOP_HALVES) + 6'(cfg.stop) + {1'b0, cfg.gap, 1'b0};
          n.ip = cfg.irda ? plen : 16'h0000;
          if (ent.brk) begin
            n.sh = 12'h000; // break holds the line low for its length
            n.nb = (ent.d[7:0] == 8'h00) ? 9'h001 : 9'(ent.d[7:0]);
          end else begin
            n.sh = fr;
            n.nb = 9'(k) + 9'(cfg.adr) + 9'(cfg.pen);
          end
        end
      end
      TX_SEND: begin
        if (tick) begin
          n.ph = ~s.ph;
          if (s.ph) begin
            n.sh = s.sh >> 1;
            n.nb = s.nb - 9'h001;
            if (s.nb == 9'h001) n.st = TX_STOP;
            else if (cfg.irda && !s.sh[1]) n.ip = plen; // pulse per zero bit
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          n.sp = s.sp - 6'h01;
          if (s.sp == 6'h01) n.st = TX_IDLE;
        end
      end
      default: n.st = TX_IDLE;
    endcase
    n.txd = cfg.irda ? (n.ip != 16'h0000) : ((n.st == TX_SEND) ? n.sh[0] : 1'b1);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.txd <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign busy = (s.st != TX_IDLE);
  assign txd = s.txd;
endmodule // asp_tx

// *** asp_rx.sv ***
// receive deserialiser: centre sampling, IrDA decode, parity, framing and break checks
// assumes rxd is asynchronous to pclk
module asp_rx (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input asp_pkg::asp_cfg_t cfg, // character format
  input wire logic rxd, // serial input pin
  output asp_pkg::asp_rxr_t res // one-cycle result
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asp_rxst_t;
  typedef struct packed {
    asp_rxst_t st;
    logic s1;
    logic s2;
    logic lp;
    logic [16:0] ir;
    logic [15:0] dv;
    logic ph;
    logic [3:0] idx;
    logic [9:0] v;
    asp_pkg::asp_rxr_t res;
  } asp_rx_st_t;
  asp_rx_st_t s, n;
  logic tick, line, brk, parb;
  logic [3:0] nbits;
  logic [9:0] hi;
  logic [7:0] dm;

  // sampling engine
  always_comb begin
    n = s;
    n.s1 = rxd;
    n.s2 = s.s1;
    n.res.vld = 1'b0;
    // IrDA pulse stretched to one bit, high pulse means zero
    if (s.s2) n.ir = {cfg.div, 1'b1};
    else if (s.ir != 17'h00000) n.ir = s.ir - 17'h00001;
    line = cfg.irda ? (s.ir == 17'h00000) : s.s2;
    n.lp = line;
    tick = (s.dv == 16'h0000);
    n.dv = tick ? cfg.div : s.dv - 16'h0001;
    nbits = 4'(cfg.len) + 4'(asp_pkg::BASE_LEN) + 4'(cfg.adr) + 4'(cfg.pen);
    hi = s.v >> (4'(cfg.len) + 4'(asp_pkg::BASE_LEN));
    dm = s.v[7:0] & (8'hFF >> (2'h3 - cfg.len));
    parb = cfg.adr ? hi[1] : hi[0];
    brk = !line && (s.v == 10'h000);
    case (s.st)
      RX_IDLE: begin
        if (s.lp && !line) begin
          n.st = RX_START; // falling start edge
          n.dv = cfg.div;
        end
      end
      RX_START: begin
        if (tick) begin
          n.st = line ? RX_IDLE : RX_BITS; // centre of start bit
          n.ph = 1'b0;
          n.idx = 4'h0;
          n.v = 10'h000;
        end
      end
      RX_BITS: begin
        if (tick) begin
          n.ph = ~s.ph;
          if (s.ph) begin
            n.v[s.idx] = line;
            n.idx = s.idx + 4'h1;
            if (s.idx == nbits - 4'h1) n.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          n.ph = ~s.ph;
          if (s.ph) begin
            n.st = RX_IDLE;
            n.res.vld = 1'b1;
            n.res.d = {cfg.adr & hi[0], dm};
            n.res.perr = cfg.pen && ((^dm) ^ parb ^ cfg.podd);
            n.res.ferr = !line && !brk;
            n.res.brk = brk;
          end
        end
      end
      default: n.st = RX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.s1 <= 1'b1;
      s.s2 <= 1'b1;
      s.lp <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign res = s.res;
endmodule // asp_rx

// *** asp_top_assertions.sv ***
// bus-side checks of the dual serial port
// assumes it is bound to asp_top and sees only its ports
module asp_chk #(
  parameter int NPORT = 2, // number of serial ports
  parameter int DEPTH = 4 // queue depth
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // bus select
  input wire logic penable, // bus access phase
  input wire logic pwrite, // bus direction
  input wire logic [asp_pkg::ADDR_W-1:0] paddr, // bus byte address
  input wire logic [31:0] prdata, // bus read data
  input wire logic pready, // bus ready
  input wire logic pslverr // bus error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting, then split by address decode
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence bad_s;
    acc_s ##0 (paddr[4:2] == 3'h7 || paddr >= NPORT * 32);
  endsequence
  sequence good_s;
    acc_s ##0 (paddr[4:2] != 3'h7 && paddr < NPORT * 32 && paddr[1:0] == 2'h0);
  endsequence
  ready_wait_a: assert property (acc_s |=> pready)
    else $error("ready missing after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (!(psel && penable) |=> !pready)
    else $error("ready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write returned data");
  unmapped_err_a: assert property (bad_s |=> pslverr)
    else $error("unmapped address accepted");
  mapped_ok_a: assert property (good_s |=> !pslverr)
    else $error("mapped address refused");
endmodule // asp_chk

bind asp_top asp_chk #(.NPORT(NPORT), .DEPTH(DEPTH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** asp_peer.sv ***
// behavioural far-end serial device: decodes one line, drives the other
// assumes both ends share bit time, length and parity
module asp_peer #(
  parameter int DIV = 3 // half bit is DIV+1 clocks
) (
  input wire logic pclk, // system clock
  input wire logic txd, // line from the port
  input wire logic [3:0] nb, // data, address and parity bits per frame
  output logic rxd // line into the port, idle high
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 2 * (DIV + 1);
  logic [9:0] got; // last frame, stop bit above the last bit
  int frames; // frames decoded
  initial begin
    rxd = 1'b1;
    got = '0;
    frames = 0;
  end
  // decode: centre of start, then one sample per bit time
  always begin
    @(negedge txd);
    got = '0;
    repeat (BT / 2) @(posedge pclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (BT) @(posedge pclk);
      got[i] = txd;
    end
    frames++;
  end
  // send start, bits LSB first, then idle stop time
  task automatic send(input logic [9:0] v);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (BT) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= v[i];
      repeat (BT) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (2 * BT) @(posedge pclk);
  endtask
endmodule // asp_peer

// *** asp_top_tb.sv ***
// self-checking bench of the dual serial port with a peer on each line
// assumes the bus answers with one wait state and DIV is set to DV
module asp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DV = 3;
  localparam int BT = 2 * (DV + 1);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, rnd;
  logic [1:0] rxd, cts_n, txd, rts_n, dma_tx_req, dma_rx_req;
  logic [3:0] nb0, nb1;
  logic [9:0] ex;
  logic [7:0] sent [5];
  int failures, samples_checked, n;

  asp_top #(.NPORT(2), .DEPTH(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq));
  asp_peer #(.DIV(DV)) peer0 (.pclk(pclk), .txd(txd[0]), .nb(nb0), .rxd(rxd[0]));
  asp_peer #(.DIV(DV)) peer1 (.pclk(pclk), .txd(txd[1]), .nb(nb1), .rxd(rxd[1]));

  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected line bits: data, parity if any, then the stop bit
  function automatic logic [9:0] frame(input logic [7:0] d, input int len, input int par);
    logic [9:0] f;
    f = 10'(d & ((8'h01 << len) - 8'h01));
    if (par != 0) f[len] = (^f) ^ (par == 2);
    f[len + (par != 0)] = 1'b1;
    return f;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up(input string nm);
    failures++;
    $display("BAD %s expected done seen timeout", nm);
    print_verdict();
  endtask

  // one bus transfer: setup, access until ready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_q = prdata;
    err_q = pslverr;
    if (k >= 50) give_up("ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input int p, input logic [2:0] r);
    apb(1'b0, 12'(p * 32 + r * 4), 32'h0);
  endtask

  task automatic wr(input int p, input logic [2:0] r, input logic [31:0] d);
    apb(1'b1, 12'(p * 32 + r * 4), d);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask

  task automatic poll(input int p, input int b);
    int k;
    k = 0;
    do begin
      rd(p, asp_pkg::REG_STAT);
      k++;
    end while (rd_q[b] !== 1'b1 && k < 100);
    if (k >= 100) give_up("status");
  endtask

  task automatic wait_frame(input int was);
    int k;
    for (k = 0; k < 400 && peer0.frames == was; k++) @(posedge pclk);
    if (k >= 400) give_up("frame");
  endtask

  // wait for txd[0] to reach a level, then count the cycles it stays there
  task automatic run_len(input logic lv, output int c);
    for (c = 0; c < 300 && txd[0] !== lv; c++) @(posedge pclk);
    if (c >= 300) give_up("line level");
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (txd[0] === lv && c < 999);
    if (c >= 999) give_up("line run");
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cts_n = 2'b00;
    nb0 = 4'h8;
    nb1 = 4'h9;
    failures = 0;
    samples_checked = 0;
    rnd = 32'hEC01;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      rd(p, asp_pkg::REG_CTRL);
      chk("ctrl reset", 32'h0003, rd_q);
      rd(p, asp_pkg::REG_DIV);
      chk("div reset", 32'h0004, rd_q);
      rd(p, asp_pkg::REG_THR);
      chk("thr reset", 32'h0013, rd_q);
      wr(p, asp_pkg::REG_DIV, DV);
    end
    chk("rts idle", 2'b00, rts_n);
    chk("txd idle", 2'b11, txd);
    apb(1'b0, 12'h01C, 32'h0);
    chk("slverr hole", 1'b1, err_q);
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr port", 1'b1, err_q);
    $display("test reset done");
    for (int len = 0; len < 4; len++) begin
      for (int par = 0; par < 3; par++) begin
        rnd = lfsr(rnd);
        wr(0, asp_pkg::REG_CTRL, 32'(len) | (par != 0 ? 32'h4 : 32'h0) | (par == 2 ? 32'h8 : 32'h0));
        nb0 <= 4'(len + 5 + (par != 0));
        n = peer0.frames;
        wr(0, asp_pkg::REG_DATA, {24'h0, rnd[7:0]});
        wait_frame(n);
        chk("tx frame", 32'(frame(rnd[7:0], len + 5, par)), 32'(peer0.got));
      end
    end
    $display("test formats done");
    wr(1, asp_pkg::REG_CTRL, 32'h0407);
    wr(1, asp_pkg::REG_MASK, 32'h0001);
    rnd = lfsr(rnd);
    ex = frame(rnd[15:8], 8, 1);
    n = peer0.frames;
    fork
      peer1.send(ex);
      wr(0, asp_pkg::REG_DATA, {24'h0, rnd[7:0]});
    join
    wait_frame(n);
    chk("duplex tx", 32'(frame(rnd[7:0], 8, 2)), 32'(peer0.got));
    poll(1, asp_pkg::ST_RXD);
    settle();
    chk("irq rx", 1'b1, irq);
    chk("dma rx", 2'b10, dma_rx_req);
    rd(1, asp_pkg::REG_DATA);
    chk("rx data", {24'h0, rnd[15:8]}, {23'h0, rd_q[8:0]});
    wr(1, asp_pkg::REG_STAT, 32'h0001);
    settle();
    chk("irq clear", 1'b0, irq);
    peer1.send(ex ^ 10'h100);
    poll(1, asp_pkg::ST_PERR);
    wr(1, asp_pkg::REG_STAT, 32'h0001);
    settle();
    chk("irq masked", 1'b0, irq);
    wr(1, asp_pkg::REG_MASK, 32'h0002);
    settle();
    chk("irq parity", 1'b1, irq);
    wr(1, asp_pkg::REG_STAT, 32'h003F);
    rd(1, asp_pkg::REG_DATA);
    settle();
    chk("irq done", 1'b0, irq);
    chk("dma rx empty", 2'b00, dma_rx_req);
    $display("test receive done");
    cts_n <= 2'b01;
    wr(0, asp_pkg::REG_CTRL, 32'h0083);
    nb0 <= 4'h8;
    n = peer0.frames;
    wr(0, asp_pkg::REG_DATA, 32'h00A5);
    repeat (4 * BT) @(posedge pclk);
    chk("cts hold", n, peer0.frames);
    cts_n <= 2'b00;
    wait_frame(n);
    chk("cts go", 32'h01A5, 32'(peer0.got));
    wr(1, asp_pkg::REG_CTRL, 32'h0483);
    nb1 <= 4'h8;
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      sent[i] = rnd[7:0];
      peer1.send({2'b00, sent[i]});
      if (i == 2) chk("rts off", 1'b1, rts_n[1]);
    end
    poll(1, asp_pkg::ST_OVR);
    for (int i = 0; i < 4; i++) begin
      rd(1, asp_pkg::REG_DATA);
      chk("rx queue", {24'h0, sent[i]}, {23'h0, rd_q[8:0]});
    end
    settle();
    chk("rts on", 1'b0, rts_n[1]);
    $display("test flow done");
    // two and a half stop bits plus one gap bit between two queued frames
    wr(0, asp_pkg::REG_CTRL, 32'h0863);
    wr(0, asp_pkg::REG_DATA, 32'h0000);
    wr(0, asp_pkg::REG_DATA, 32'h0000);
    run_len(1'b1, n);
    chk("stop gap", 1'b1, 1'((n >= 7 * BT / 2) && (n <= 7 * BT / 2 + 3)));
    // multi-drop: foreign address dropped, own address and its data kept
    wr(1, asp_pkg::REG_THR, 32'h5A13);
    wr(1, asp_pkg::REG_CTRL, 32'h0013);
    nb1 <= 4'h9;
    peer1.send(10'h1C3);
    peer1.send(10'h15A);
    peer1.send(10'h066);
    rd(1, asp_pkg::REG_DATA);
    chk("own address", 32'h015A, {23'h0, rd_q[8:0]});
    rd(1, asp_pkg::REG_DATA);
    chk("listened data", 32'h0066, {23'h0, rd_q[8:0]});
    rd(1, asp_pkg::REG_STAT);
    chk("foreign dropped", 1'b0, rd_q[8]);
    // infrared start pulse of three sixteenths of a bit
    wr(0, asp_pkg::REG_CTRL, 32'h0103);
    wr(0, asp_pkg::REG_DATA, 32'h0000);
    run_len(1'b1, n);
    chk("ir pulse", 3 * BT / 16, n);
    repeat (12 * BT) @(posedge pclk);
    $display("test options done");
    wr(0, asp_pkg::REG_CTRL, 32'h0203);
    settle();
    chk("dma tx", 2'b01, dma_tx_req);
    wr(0, asp_pkg::REG_BRK, 32'h0003);
    run_len(1'b0, n);
    chk("break length", 3 * BT, n);
    $display("test break done");
    print_verdict();
  end
endmodule // asp_top_tb
